// ### common/cos_pkg.sv
package cos_pkg;

	// ************************************************************
	// channel count and value limits
	// ************************************************************
	localparam int          NUM_CHANNELS       = 8;
	localparam int          CHAN_BITS          = 3;
	localparam logic [15:0] SPAN_MAX_UA        = 16'h4E20;   // 20,000 microamps
	localparam logic [15:0] DAC_MAX_CODE       = 16'h4E20;   // top of the converter range
	localparam logic [15:0] DAC_ZERO_CODE      = 16'h0000;   // zero current
	localparam logic [15:0] OPEN_WIRE_SPAN_UA  = 16'h0DAC;   // 3,500 microamps
	localparam logic [15:0] OPEN_WIRE_TRIP_UA  = 16'h07D0;   // 2,000 microamps
	localparam logic [3:0]  WORD_COUNT_MAX     = 4'h8;

	// ************************************************************
	// scaling presets
	// ************************************************************
	localparam logic [1:0]  PRESET_CUSTOM      = 2'h0;
	localparam logic [1:0]  PRESET_ONE         = 2'h1;
	localparam logic [1:0]  PRESET_TWO         = 2'h2;
	localparam logic [1:0]  PRESET_THREE       = 2'h3;

	localparam logic signed [15:0] P1_EU_LOW   = 16'h0FA0;   // 4,000
	localparam logic signed [15:0] P1_EU_HIGH  = 16'h4E20;   // 20,000
	localparam logic signed [15:0] P23_EU_LOW  = 16'h0000;   // 0
	localparam logic signed [15:0] P23_EU_HIGH = 16'h7D00;   // 32,000
	localparam logic [15:0] P12_SPAN_LOW       = 16'h0FA0;   // 4,000 microamps
	localparam logic [15:0] P3_SPAN_LOW        = 16'h0000;   // 0 microamps
	localparam logic [15:0] P123_SPAN_HIGH     = 16'h4E20;   // 20,000 microamps

	// ************************************************************
	// carriers
	// ************************************************************
	typedef struct packed {
		logic                active;
		logic signed [15:0]  eu_low;
		logic signed [15:0]  eu_high;
		logic [15:0]         span_low;
		logic [15:0]         span_high;
	} cos_chan_cfg_t;

	typedef struct packed {
		logic [1:0]          preset;
		cos_chan_cfg_t       cfg;
	} cos_cfg_req_t;

	typedef struct packed {
		logic [CHAN_BITS-1:0] chan;
		logic signed [15:0]   value;
	} cos_word_t;

	localparam cos_chan_cfg_t CFG_RESET = '{
		active:    1'b1,
		eu_low:    P1_EU_LOW,
		eu_high:   P1_EU_HIGH,
		span_low:  P12_SPAN_LOW,
		span_high: P123_SPAN_HIGH
	};

endpackage : cos_pkg

// ### logic/cos_scaler.sv
`timescale 1ns/1ps
module cos_scaler
	import cos_pkg::*;
(
	input  wire cos_chan_cfg_t      cfg_in,
	input  wire logic signed [15:0] word_in,
	output logic [15:0]             code_out
);

	// ************************************************************
	// constant-slope mapping through the low and high points
	// ************************************************************
	always_comb begin
		logic signed [16:0] eu_diff;
		logic signed [16:0] eu_den;
		logic signed [16:0] span_diff;
		logic signed [33:0] prod;
		logic signed [33:0] quot;
		logic signed [34:0] sum;
		eu_diff   = {word_in[15], word_in} - {cfg_in.eu_low[15], cfg_in.eu_low};
		eu_den    = {cfg_in.eu_high[15], cfg_in.eu_high} - {cfg_in.eu_low[15], cfg_in.eu_low};
		span_diff = $signed({1'b0, cfg_in.span_high}) - $signed({1'b0, cfg_in.span_low});
		if (eu_den == 17'sh0) begin
			eu_den = 17'sh1;   // guard only, result replaced below
		end
		prod = 34'(eu_diff) * 34'(span_diff);
		quot = prod / 34'(eu_den);
		// no clamp at the points, the line carries on past them
		sum  = 35'(quot) + $signed({19'h0, cfg_in.span_low});
		if (cfg_in.span_low == cfg_in.span_high) begin
			code_out = cfg_in.span_low;
		end else if (cfg_in.eu_low == cfg_in.eu_high) begin
			code_out = (word_in < cfg_in.eu_low) ? DAC_ZERO_CODE : DAC_MAX_CODE;
		end else if (sum < 35'sh0) begin
			code_out = DAC_ZERO_CODE;
		end else if (sum > $signed({19'h0, DAC_MAX_CODE})) begin
			code_out = DAC_MAX_CODE;
		end else begin
			code_out = sum[15:0];
		end
	end

endmodule : cos_scaler

// ### logic/cos_output_scaler.sv
`timescale 1ns/1ps
module cos_output_scaler
	import cos_pkg::*;
#(
	parameter int NCH = NUM_CHANNELS
)
(
	input  wire logic                 clk_in,
	input  wire logic                 reset_n_in,
	input  wire logic                 module_reset_in,
	input  wire logic                 local_fail_in,
	input  wire logic                 hold_last_in,
	input  wire logic [3:0]           word_count_in,
	input  wire logic                 word_valid_in,
	input  wire cos_word_t            analog_output_word_in,
	output logic                      word_ready_out,
	input  wire logic                 cfg_valid_in,
	input  wire logic [CHAN_BITS-1:0] cfg_chan_in,
	input  wire cos_cfg_req_t         cfg_in,
	output logic                      cfg_accept_out,
	output logic                      cfg_reject_out,
	input  wire logic [NCH-1:0]       alarm_clear_in,
	output logic [NCH*16-1:0]         dac_code_out,
	output logic [NCH-1:0]            channel_active_out,
	output logic [NCH-1:0]            open_wire_armed_out,
	output logic [NCH-1:0]            open_wire_alarm_out,
	output logic                      default_active_out
);

	// ************************************************************
	// state of the block
	// ************************************************************
	typedef struct packed {
		logic [1:0]                fail_sync;
		cos_chan_cfg_t [NCH-1:0]   cfg;
		logic [NCH-1:0][15:0]      code;
		logic [NCH-1:0]            alarm;
		logic                      cfg_accept;
		logic                      cfg_reject;
	} cos_state_t;

	cos_state_t state;
	cos_state_t next_state;

	// ************************************************************
	// decoded request and scaler
	// ************************************************************
	cos_chan_cfg_t     cfg_resolved;
	cos_chan_cfg_t     word_cfg;
	logic [15:0]       scaled_code;
	logic              fail_now;
	logic              in_default;
	logic              cfg_ok;
	logic              word_fed;

	// failure pin after two flops, default on failure or module reset
	assign fail_now   = state.fail_sync[1];
	assign in_default = fail_now | module_reset_in;

	// words are taken whenever no default is in force
	assign word_ready_out = ~in_default;

	// only channels within the configured word count are fed
	assign word_fed = ({1'b0, analog_output_word_in.chan} < word_count_in) &&
		(word_count_in <= WORD_COUNT_MAX);

	// preset points override the supplied points
	always_comb begin
		cfg_resolved        = cfg_in.cfg;
		cfg_resolved.active = cfg_in.cfg.active;
		unique case (cfg_in.preset)
			PRESET_ONE: begin
				cfg_resolved.eu_low    = P1_EU_LOW;
				cfg_resolved.eu_high   = P1_EU_HIGH;
				cfg_resolved.span_low  = P12_SPAN_LOW;
				cfg_resolved.span_high = P123_SPAN_HIGH;
			end
			PRESET_TWO: begin
				cfg_resolved.eu_low    = P23_EU_LOW;
				cfg_resolved.eu_high   = P23_EU_HIGH;
				cfg_resolved.span_low  = P12_SPAN_LOW;
				cfg_resolved.span_high = P123_SPAN_HIGH;
			end
			PRESET_THREE: begin
				cfg_resolved.eu_low    = P23_EU_LOW;
				cfg_resolved.eu_high   = P23_EU_HIGH;
				cfg_resolved.span_low  = P3_SPAN_LOW;
				cfg_resolved.span_high = P123_SPAN_HIGH;
			end
			PRESET_CUSTOM: begin
				cfg_resolved.eu_low    = cfg_in.cfg.eu_low;
				cfg_resolved.eu_high   = cfg_in.cfg.eu_high;
				cfg_resolved.span_low  = cfg_in.cfg.span_low;
				cfg_resolved.span_high = cfg_in.cfg.span_high;
			end
		endcase
	end

	// span limits and ordering checked before a point set is kept
	assign cfg_ok = (cfg_resolved.span_low <= SPAN_MAX_UA) &&
		(cfg_resolved.span_high <= SPAN_MAX_UA) &&
		(cfg_resolved.span_high >= cfg_resolved.span_low);

	// settings of the channel the current word addresses
	assign word_cfg = state.cfg[analog_output_word_in.chan];

	cos_scaler u_scaler (
		.cfg_in   (word_cfg),
		.word_in  (analog_output_word_in.value),
		.code_out (scaled_code)
	);

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		next_state            = state;
		next_state.fail_sync  = {state.fail_sync[0], local_fail_in};
		next_state.cfg_accept = 1'b0;
		next_state.cfg_reject = 1'b0;

		// configuration writes, a bad span pair is refused whole
		if (cfg_valid_in) begin
			if (cfg_ok) begin
				next_state.cfg[cfg_chan_in] = cfg_resolved;
				next_state.cfg_accept       = 1'b1;
			end else begin
				next_state.cfg_reject       = 1'b1;
			end
		end

		// a module reset restores the default point sets
		if (module_reset_in) begin
			for (int i = 0; i < NCH; i++) begin
				next_state.cfg[i] = CFG_RESET;
			end
		end

		// accepted word updates the addressed active channel
		if (word_valid_in && !in_default && word_fed) begin
			if (word_cfg.active) begin
				next_state.code[analog_output_word_in.chan] = scaled_code;
			end
		end

		// default output during failure or module reset
		if (in_default && !hold_last_in) begin
			for (int i = 0; i < NCH; i++) begin
				next_state.code[i] = DAC_ZERO_CODE;
			end
		end
		// hold-last leaves the code of every active channel where it was

		// inactive channels sit at zero current
		for (int i = 0; i < NCH; i++) begin
			if (!state.cfg[i].active) begin
				next_state.code[i] = DAC_ZERO_CODE;
			end
		end

		// open wire: clear by host bit, new trip wins over clear
		for (int i = 0; i < NCH; i++) begin
			if (alarm_clear_in[i]) begin
				next_state.alarm[i] = 1'b0;
			end
			if (state.cfg[i].active && (state.cfg[i].span_low > OPEN_WIRE_SPAN_UA) &&
				(state.code[i] < OPEN_WIRE_TRIP_UA)) begin
				next_state.alarm[i] = 1'b1;
			end
		end
	end

	// ************************************************************
	// state register
	// ************************************************************
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state.fail_sync  <= 2'h0;
			state.cfg        <= {NCH{CFG_RESET}};
			state.code       <= '0;
			state.alarm      <= '0;
			state.cfg_accept <= 1'b0;
			state.cfg_reject <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign dac_code_out       = state.code;
	assign open_wire_alarm_out = state.alarm;
	assign cfg_accept_out     = state.cfg_accept;
	assign cfg_reject_out     = state.cfg_reject;
	assign default_active_out = in_default;

	// per-channel status taken from the stored settings
	for (genvar g = 0; g < NCH; g++) begin : g_status
		assign channel_active_out[g]  = state.cfg[g].active;
		assign open_wire_armed_out[g] = state.cfg[g].span_low > OPEN_WIRE_SPAN_UA;
	end

endmodule : cos_output_scaler

// ### sim/cos_output_scaler_monitor.sv
`timescale 1ns/1ps
module cos_output_scaler_monitor
	import cos_pkg::*;
#(
	parameter int NCH = NUM_CHANNELS
)
(
	input wire logic              clk_in,
	input wire logic              reset_n_in,
	input wire logic              module_reset_in,
	input wire logic              local_fail_in,
	input wire logic              hold_last_in,
	input wire logic              cfg_valid_in,
	input wire logic [NCH-1:0]    alarm_clear_in,
	input wire logic              cfg_accept_out,
	input wire logic              cfg_reject_out,
	input wire logic [NCH*16-1:0] dac_code_out,
	input wire logic [NCH-1:0]    channel_active_out,
	input wire logic [NCH-1:0]    open_wire_armed_out,
	input wire logic [NCH-1:0]    open_wire_alarm_out,
	input wire logic              default_active_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!reset_n_in);
	// channel zero code and its open wire trip condition
	wire [15:0] c0    = dac_code_out[15:0];
	wire        trip0 = channel_active_out[0] & open_wire_armed_out[0] & (c0 < OPEN_WIRE_TRIP_UA);
	// failure held through both sync stages
	sequence s_fail;
		$rose(local_fail_in) ##0 local_fail_in [*3];
	endsequence
	AST_FAIL_DEFAULT: assert property (s_fail |-> default_active_out)
		else $error("failure did not enter default");
	AST_ZERO_DEFAULT: assert property (default_active_out && !hold_last_in |=> dac_code_out == '0)
		else $error("zero default left a code");
	AST_HOLD_DEFAULT: assert property (default_active_out && hold_last_in |=> $stable(dac_code_out))
		else $error("hold default changed a code");
	AST_INACTIVE_ZERO: assert property (!channel_active_out[0] |=> c0 == DAC_ZERO_CODE)
		else $error("inactive channel drives current");
	AST_NO_NEW_ALARM: assert property ($rose(open_wire_alarm_out[0]) |-> $past(channel_active_out[0]))
		else $error("inactive channel raised alarm");
	AST_ALARM_SET: assert property (trip0 |=> open_wire_alarm_out[0])
		else $error("open wire alarm missed");
	AST_ALARM_CLEAR: assert property (alarm_clear_in[0] && !trip0 |=> !open_wire_alarm_out[0])
		else $error("alarm not cleared");
	AST_CFG_ANSWER: assert property (cfg_valid_in && !module_reset_in |=> cfg_accept_out ^ cfg_reject_out)
		else $error("config write not answered once");
	AST_SATURATE: assert property (dac_code_out[31:16] <= DAC_MAX_CODE)
		else $error("code beyond converter range");
endmodule : cos_output_scaler_monitor

bind cos_output_scaler cos_output_scaler_monitor #(.NCH(NCH)) u_mon (
	.clk_in, .reset_n_in, .module_reset_in, .local_fail_in, .hold_last_in, .cfg_valid_in,
	.alarm_clear_in, .cfg_accept_out, .cfg_reject_out, .dac_code_out, .channel_active_out,
	.open_wire_armed_out, .open_wire_alarm_out, .default_active_out
);

// ### sim/cos_bus_unit_model.sv
`timescale 1ns/1ps
module cos_bus_unit_model
	import cos_pkg::*;
(
	input  wire logic clk_in,
	input  wire logic ready_in,
	output logic      word_valid_out,
	output cos_word_t word_out
);
	initial begin
		word_valid_out = 1'b0;
		word_out = '0;
	end
	// one word after a gap, held until taken or given up
	task automatic send(input int ch, input int v, input int gap);
		int n;
		repeat (gap + 1) @(negedge clk_in);
		word_valid_out <= 1'b1;
		word_out <= '{chan: ch[2:0], value: v[15:0]};
		n = 0;
		@(posedge clk_in);
		// give up after six edges without ready
		while (!ready_in && n < 5) begin
			n++;
			@(posedge clk_in);
		end
		@(negedge clk_in);
		word_valid_out <= 1'b0;
		word_out <= ~word_out; // released bus shows no stale word
	endtask : send
endmodule : cos_bus_unit_model

// ### sim/cos_output_scaler_test.sv
`timescale 1ns/1ps
module cos_output_scaler_test
	import cos_pkg::*;
();
	logic         clk_in, reset_n_in, module_reset_in, local_fail_in, hold_last_in;
	logic         cfg_valid_in, word_valid_in, word_ready_out, cfg_accept_out;
	logic         cfg_reject_out, default_active_out;
	logic [3:0]   word_count_in;
	logic [2:0]   cfg_chan_in;
	cos_cfg_req_t cfg_in;
	cos_word_t    analog_output_word_in;
	logic [127:0] dac_code_out;
	logic [7:0]   alarm_clear_in, channel_active_out, open_wire_armed_out, open_wire_alarm_out;
	int           err_total, checked;
	cos_output_scaler uut (.clk_in, .reset_n_in, .module_reset_in, .local_fail_in,
		.hold_last_in, .word_count_in, .word_valid_in, .analog_output_word_in,
		.word_ready_out, .cfg_valid_in, .cfg_chan_in, .cfg_in, .cfg_accept_out,
		.cfg_reject_out, .alarm_clear_in, .dac_code_out, .channel_active_out,
		.open_wire_armed_out, .open_wire_alarm_out, .default_active_out);
	cos_bus_unit_model bus (.clk_in, .ready_in(word_ready_out),
		.word_valid_out(word_valid_in), .word_out(analog_output_word_in));
	initial begin
		clk_in = 1'b0;
		forever #4 clk_in = ~clk_in;
	end
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	function automatic logic [15:0] code(input int ch);
		return dac_code_out[ch*16 +: 16];
	endfunction : code
	// reference mapping: constant slope, truncating, saturated
	function automatic logic [15:0] ref_code(input int el, eh, sl, sh, v);
		longint r;
		if (sh == sl) r = sl;
		else if (eh == el) r = (v < el) ? 0 : 20000;
		else r = sl + (longint'(v - el) * (sh - sl)) / (eh - el);
		if (r < 0) r = 0;
		if (r > 20000) r = 20000;
		return r[15:0];
	endfunction : ref_code
	task automatic put(input int ch, v, gap, input logic [15:0] e);
		bus.send(ch, v, gap);
		check("code", code(ch), e);
	endtask : put
	task automatic configure(input int ch, p, act, el, eh, sl, sh, ok);
		@(negedge clk_in);
		cfg_valid_in <= 1'b1;
		cfg_chan_in <= ch[2:0];
		cfg_in <= '{p[1:0], '{act[0], el[15:0], eh[15:0], sl[15:0], sh[15:0]}};
		@(negedge clk_in);
		cfg_valid_in <= 1'b0;
		check("accept", cfg_accept_out, ok[0]);
		check("reject", cfg_reject_out, !ok[0]);
	endtask : configure
	task automatic clear_alarm(input int ch);
		@(negedge clk_in);
		alarm_clear_in[ch] <= 1'b1;
		@(negedge clk_in);
		alarm_clear_in[ch] <= 1'b0;
		check("cleared", open_wire_alarm_out[ch], 0);
	endtask : clear_alarm
	task automatic t_reset;
		for (int i = 0; i < 8; i++) check("reset code", code(i), DAC_ZERO_CODE);
		check("active", channel_active_out, 8'hFF);
		check("armed", open_wire_armed_out, 8'hFF);
		$display("reset test done");
	endtask : t_reset
	task automatic t_presets;
		int v[4] = '{-32768, 1000, 12000, 32767};
		int el, eh, sl;
		for (int p = 1; p < 4; p++) begin
			el = (p == 1) ? 4000 : 0;
			eh = (p == 1) ? 20000 : 32000;
			sl = (p == 3) ? 0 : 4000;
			configure(1, p, 1, el, eh, sl, 20000, 1);
			check("armed", open_wire_armed_out[1], p != 3);
			foreach (v[i]) put(1, v[i], i, ref_code(el, eh, sl, 20000, v[i]));
		end
		$display("preset test done");
	endtask : t_presets
	task automatic t_custom;
		configure(3, 0, 1, 100, 100, 1000, 15000, 1);
		put(3, 99, 0, 16'h0000);
		put(3, 100, 0, 16'h4E20);
		configure(3, 0, 1, -500, 500, 10000, 10000, 1);
		put(3, -32768, 0, 16'h2710);
		configure(3, 0, 1, -32768, 32767, 0, 20000, 1);
		put(3, 1, 1, ref_code(-32768, 32767, 0, 20000, 1));
		configure(3, 0, 1, 0, 100, 5000, 4999, 0);
		configure(3, 0, 1, 0, 100, 0, 20001, 0);
		// old points must still map, the refused pairs give other codes
		put(3, -16384, 0, ref_code(-32768, 32767, 0, 20000, -16384));
		$display("custom test done");
	endtask : t_custom
	task automatic t_alarm;
		put(0, 12000, 0, 16'h2EE0);
		clear_alarm(0);
		put(0, 1000, 0, 16'h03E8);
		@(negedge clk_in);
		check("alarm", open_wire_alarm_out[0], 1);
		configure(0, 0, 0, 4000, 20000, 4000, 20000, 1);
		@(negedge clk_in);
		check("inactive code", code(0), 0);
		check("latched", open_wire_alarm_out[0], 1);
		clear_alarm(0);
		@(negedge clk_in);
		check("no new alarm", open_wire_alarm_out[0], 0);
		$display("alarm test done");
	endtask : t_alarm
	task automatic t_default;
		put(5, 9000, 0, 16'h2328);
		word_count_in <= 4'h2;
		put(5, 15000, 0, 16'h2328);
		put(1, 8000, 0, 16'h1388);
		word_count_in <= WORD_COUNT_MAX;
		hold_last_in <= 1'b1;
		module_reset_in <= 1'b1;
		put(5, 20000, 2, 16'h2328);
		check("ready in default", word_ready_out, 0);
		check("default flag", default_active_out, 1);
		hold_last_in <= 1'b0;
		repeat (2) @(negedge clk_in);
		check("zero default", code(5), 0);
		module_reset_in <= 1'b0;
		put(5, 9000, 0, 16'h2328);
		local_fail_in <= 1'b1;
		repeat (4) @(negedge clk_in);
		check("fail default", code(5), 0);
		check("fail flag", default_active_out, 1);
		local_fail_in <= 1'b0;
		$display("default test done");
	endtask : t_default
	task automatic complete_run;
		$display("checked %0d err_total %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : complete_run
	initial begin
		{reset_n_in, module_reset_in, local_fail_in, hold_last_in, cfg_valid_in} = '0;
		word_count_in = WORD_COUNT_MAX;
		cfg_chan_in = '0;
		cfg_in = '0;
		alarm_clear_in = '0;
		err_total = 0;
		checked = 0;
		repeat (3) @(negedge clk_in);
		reset_n_in = 1'b1;
		t_reset;
		t_presets;
		t_custom;
		t_alarm;
		t_default;
		complete_run;
	end
	// watchdog well beyond the hundred or so cycles the tests need
	initial begin
		#40000;
		err_total++;
		complete_run;
	end
endmodule : cos_output_scaler_test
